// file: verilog/hsc_pkg.sv
// Package for the high-speed conditioner strap and status flag logic.
// Assumes a 100 MHz system clock; all pins already synchronous.
package hsc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CHIRP_MIN_US = 18;
  localparam int unsigned CHIRP_MAX_US = 128;
  // Least time rounds up, longest rounds down (integer MHz exact)
  localparam int unsigned CHIRP_MIN_CYC = CHIRP_MIN_US * CLK_MHZ;
  localparam int unsigned CHIRP_MAX_CYC = CHIRP_MAX_US * CLK_MHZ;
  localparam int unsigned CNT_W = 15;
  localparam logic [6:0] MGMT_ADDR = 7'h2c;
  localparam logic [1:0] BOOST_FLOAT = 2'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;

  typedef enum logic [1:0] {
    HSC_SENS_LOW = 2'b00,
    HSC_SENS_MED = 2'b01,
    HSC_SENS_HIGH = 2'b10
  } hsc_sens_t;

  typedef enum logic [2:0] {
    HSC_HS_IDLE = 3'b000,
    HSC_HS_FIXTURE = 3'b001,
    HSC_HS_BUSRST = 3'b010,
    HSC_HS_CHIRP_J = 3'b011,
    HSC_HS_CHIRP_K = 3'b100,
    HSC_HS_WAIT_SQ = 3'b101,
    HSC_HS_ACTIVE = 3'b110
  } hsc_hs_state_t;
endpackage

// file: verilog/hsc_chirp_timer.sv
// Chirp duration checker: counts one chirp level and judges its length.
// Assumes the level input is synchronous and free of glitches.
`timescale 1ns/100ps
module hsc_chirp_timer
  import hsc_pkg::*;
#(
  parameter int unsigned MIN_CYC = CHIRP_MIN_CYC,
  parameter int unsigned MAX_CYC = CHIRP_MAX_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Control
  input wire logic run_i,
  // Result
  output logic in_window_o,
  output logic too_long_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } hsc_ct_state_t;

  hsc_ct_state_t st_reg;
  hsc_ct_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!run_i) begin
      st_next.cnt = CNT_ZERO;
    end else if (st_reg.cnt <= CNT_W'(MAX_CYC)) begin
      st_next.cnt = st_reg.cnt + CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  logic [CNT_W:0] run_len;

  // Entry cycle is seen before the counter starts, so add it back
  assign run_len = (CNT_W+1)'(st_reg.cnt) + (CNT_W+1)'(CNT_ONE);
  assign in_window_o = (run_len >= (CNT_W+1)'(MIN_CYC)) &&
                       (run_len <= (CNT_W+1)'(MAX_CYC));
  assign too_long_o = run_len > (CNT_W+1)'(MAX_CYC);

  AST_CT_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !run_i |=> st_reg.cnt == CNT_ZERO)
    else $error("chirp counter not cleared");
endmodule // hsc_chirp_timer

// file: verilog/hsc_strap_flags.sv
// Strap sampling and status flags of a high-speed signal conditioner.
// Assumes line-state detector inputs are synchronous one-bit levels.
`timescale 1ns/100ps
module hsc_strap_flags
  import hsc_pkg::*;
#(
  parameter int unsigned MIN_CYC = CHIRP_MIN_CYC,
  parameter int unsigned MAX_CYC = CHIRP_MAX_CYC
) (
  // Clock and reset (reset is the active-low reset pin)
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Power-up marker, high for the first cycle after supply good
  input wire logic power_up_i,
  // Strap pin levels
  input wire logic mgmt_data_pin_i,
  input wire logic mgmt_clock_attach_flag_pin_i,
  input wire logic sens_strap_high_i,
  input wire logic sens_strap_float_i,
  input wire logic boost_float_i,
  input wire logic [1:0] boost_level_i,
  // Line events from the analog front end
  input wire logic fixture_detect_i,
  input wire logic test_packet_i,
  input wire logic bus_reset_i,
  input wire logic chirp_j_i,
  input wire logic chirp_k_i,
  input wire logic squelch_i,
  input wire logic pullup_detect_i,
  input wire logic disconnect_i,
  // Management target address match
  input wire logic [6:0] mgmt_addr_i,
  output logic mgmt_addr_match_o,
  // Configuration out
  output logic mgmt_mode_o,
  output logic [1:0] rx_sensitivity_strap_o,
  output logic [1:0] boost_level_o,
  output logic shutdown_o,
  // Shared pin drivers (enable low = drive)
  output logic sensitivity_strap_hs_flag_pin_o,
  output logic sensitivity_strap_hs_flag_pin_oe_n_o,
  output logic mgmt_clock_attach_flag_pin_o,
  output logic mgmt_clock_attach_flag_pin_oe_n_o
);
  typedef struct packed {
    logic sampled;
    logic boost_done;
    logic mgmt_mode;
    logic [1:0] sens;
    logic [1:0] boost;
    hsc_hs_state_t hs;
    logic high_speed_active_flag;
    logic connection_detect_flag;
  } hsc_state_t;

  hsc_state_t st_reg;
  hsc_state_t st_next;
  logic chirp_run;
  logic chirp_ok;
  logic chirp_long;

  assign chirp_run = (st_reg.hs == HSC_HS_CHIRP_J && chirp_j_i) ||
                     (st_reg.hs == HSC_HS_CHIRP_K && chirp_k_i);

  hsc_chirp_timer #(
    .MIN_CYC(MIN_CYC),
    .MAX_CYC(MAX_CYC)
  ) u_chirp (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .run_i(chirp_run),
    .in_window_o(chirp_ok),
    .too_long_o(chirp_long)
  );

  always_comb begin
    st_next = st_reg;
    if (!st_reg.sampled) begin
      st_next.sampled = 1'b1;
      st_next.mgmt_mode = mgmt_data_pin_i && mgmt_clock_attach_flag_pin_i;
      if (sens_strap_float_i) begin
        st_next.sens = HSC_SENS_MED;
      end else if (sens_strap_high_i) begin
        st_next.sens = HSC_SENS_HIGH;
      end else begin
        st_next.sens = HSC_SENS_LOW;
      end
    end
    if (power_up_i && !st_reg.boost_done) begin
      st_next.boost_done = 1'b1;
      st_next.boost = boost_float_i ? BOOST_FLOAT : boost_level_i;
    end
    if (st_reg.sampled && !st_reg.mgmt_mode) begin
      if (!st_reg.connection_detect_flag && pullup_detect_i) begin
        st_next.connection_detect_flag = 1'b1;
      end
      if (disconnect_i) begin
        st_next.connection_detect_flag = 1'b0;
        st_next.hs = HSC_HS_IDLE;
        st_next.high_speed_active_flag = 1'b0;
      end else begin
        unique case (st_reg.hs)
          HSC_HS_IDLE: begin
            if (fixture_detect_i && !st_reg.connection_detect_flag) begin
              st_next.hs = HSC_HS_FIXTURE;
            end else if (bus_reset_i) begin
              st_next.hs = HSC_HS_BUSRST;
            end
          end
          HSC_HS_FIXTURE: begin
            if (test_packet_i) begin
              st_next.hs = HSC_HS_ACTIVE;
              st_next.high_speed_active_flag = 1'b1;
            end
          end
          HSC_HS_BUSRST: begin
            if (chirp_j_i) begin
              st_next.hs = HSC_HS_CHIRP_J;
            end
          end
          HSC_HS_CHIRP_J: begin
            if (chirp_long) begin
              st_next.hs = HSC_HS_IDLE;
            end else if (!chirp_j_i) begin
              st_next.hs = (chirp_ok && chirp_k_i) ? HSC_HS_CHIRP_K :
                                                     HSC_HS_IDLE;
            end
          end
          HSC_HS_CHIRP_K: begin
            if (chirp_long) begin
              st_next.hs = HSC_HS_IDLE;
            end else if (!chirp_k_i) begin
              st_next.hs = chirp_ok ? HSC_HS_WAIT_SQ : HSC_HS_IDLE;
            end
          end
          HSC_HS_WAIT_SQ: begin
            if (squelch_i) begin
              st_next.hs = HSC_HS_ACTIVE;
              st_next.high_speed_active_flag = 1'b1;
            end else if (chirp_j_i || chirp_k_i) begin
              // A J or K chirp seen without squelch breaks the single-pair handshake
              st_next.hs = HSC_HS_IDLE;
            end
          end
          HSC_HS_ACTIVE: begin
            if (bus_reset_i) begin
              st_next.hs = HSC_HS_BUSRST;
              st_next.high_speed_active_flag = 1'b0;
            end
          end
          default: begin
            st_next.hs = HSC_HS_IDLE;
          end
        endcase
      end
    end
  end

  // reset pin is the async reset
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mgmt_mode_o = st_reg.mgmt_mode;
  assign rx_sensitivity_strap_o = st_reg.sens;
  assign boost_level_o = st_reg.boost;
  assign shutdown_o = !nrst_i;
  assign mgmt_addr_match_o = st_reg.sampled && st_reg.mgmt_mode &&
                             (mgmt_addr_i == MGMT_ADDR);
  assign sensitivity_strap_hs_flag_pin_o = st_reg.high_speed_active_flag;
  assign sensitivity_strap_hs_flag_pin_oe_n_o =
    !(st_reg.sampled && !st_reg.mgmt_mode);
  assign mgmt_clock_attach_flag_pin_o = st_reg.connection_detect_flag;
  assign mgmt_clock_attach_flag_pin_oe_n_o =
    !(st_reg.sampled && !st_reg.mgmt_mode);

  AST_MODE_SAMPLE: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !st_reg.sampled |=> st_reg.mgmt_mode ==
      ($past(mgmt_data_pin_i) && $past(mgmt_clock_attach_flag_pin_i)))
    else $error("mode strap misread");
  // shared pins released in management mode
  AST_MGMT_QUIET: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.mgmt_mode |-> sensitivity_strap_hs_flag_pin_oe_n_o &&
      mgmt_clock_attach_flag_pin_oe_n_o && !mgmt_clock_attach_flag_pin_o)
    else $error("shared pins driven in management mode");
  AST_SENS_MED: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !st_reg.sampled && sens_strap_float_i |=> st_reg.sens == HSC_SENS_MED)
    else $error("sensitivity strap misread");
  AST_SENS_HIGH: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !st_reg.sampled && !sens_strap_float_i && sens_strap_high_i |=>
      rx_sensitivity_strap_o == HSC_SENS_HIGH)
    else $error("high sensitivity misread");
  AST_SENS_LOW: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !st_reg.sampled && !sens_strap_float_i && !sens_strap_high_i |=>
      rx_sensitivity_strap_o == HSC_SENS_LOW)
    else $error("low sensitivity misread");
  // flag pin driven in strapped mode
  AST_HS_PIN_DRIVE: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.sampled && !st_reg.mgmt_mode |->
      !sensitivity_strap_hs_flag_pin_oe_n_o)
    else $error("hs flag pin not driven");
  // flag stands until bus reset or disconnect
  AST_HS_HOLD: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    sensitivity_strap_hs_flag_pin_o && !bus_reset_i && !disconnect_i |=>
      sensitivity_strap_hs_flag_pin_o)
    else $error("hs flag dropped without cause");
  AST_FIXTURE_FLAG: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.hs == HSC_HS_FIXTURE && test_packet_i && !disconnect_i &&
      !st_reg.mgmt_mode |=> st_reg.high_speed_active_flag)
    else $error("fixture path did not set flag");
  AST_HS_CAUSE: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(st_reg.high_speed_active_flag) |->
      $past(st_reg.hs) inside {HSC_HS_FIXTURE, HSC_HS_WAIT_SQ})
    else $error("hs flag without cause");
  AST_BUSRST_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.hs == HSC_HS_ACTIVE && bus_reset_i && !disconnect_i |=>
      !sensitivity_strap_hs_flag_pin_o && st_reg.hs == HSC_HS_BUSRST)
    else $error("bus reset kept hs flag");
  AST_CHIRP_LONG: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.hs inside {HSC_HS_CHIRP_J, HSC_HS_CHIRP_K} && chirp_long &&
      !disconnect_i |=> st_reg.hs == HSC_HS_IDLE)
    else $error("long chirp accepted");
  AST_CHIRP_SHORT: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.hs == HSC_HS_CHIRP_J && !chirp_j_i && !chirp_ok &&
      !chirp_long && !disconnect_i |=> st_reg.hs == HSC_HS_IDLE)
    else $error("short chirp accepted");
  AST_ADDR: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    mgmt_addr_match_o |-> mgmt_addr_i == 7'h2c && st_reg.mgmt_mode)
    else $error("address match wrong");
  AST_ATTACH: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.sampled && !st_reg.mgmt_mode && pullup_detect_i && !disconnect_i
      |=> mgmt_clock_attach_flag_pin_o)
    else $error("attach not flagged");
  AST_DETACH: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.sampled && !st_reg.mgmt_mode && disconnect_i
      |=> !st_reg.connection_detect_flag && !st_reg.high_speed_active_flag)
    else $error("disconnect not cleared");
  AST_ATTACH_HOLD: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    mgmt_clock_attach_flag_pin_o && !disconnect_i |=>
      mgmt_clock_attach_flag_pin_o)
    else $error("attach flag dropped");
  AST_BOOST_HOLD: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.boost_done |=> $stable(st_reg.boost))
    else $error("boost changed after power-up");
  // floating boost strap gives level 3
  AST_BOOST_FLOAT: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    power_up_i && !st_reg.boost_done && boost_float_i |=>
      boost_level_o == 2'h3)
    else $error("floating boost misread");
  AST_FLAGS_START: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !st_reg.sampled |-> !st_reg.high_speed_active_flag &&
      !st_reg.connection_detect_flag)
    else $error("flags set after reset");

  COV_FIXTURE: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.hs == HSC_HS_FIXTURE ##1 st_reg.high_speed_active_flag);
  COV_HANDSHAKE: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.hs == HSC_HS_WAIT_SQ ##1 st_reg.hs == HSC_HS_ACTIVE);
  COV_ATTACH: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(st_reg.connection_detect_flag));
  COV_MGMT: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    mgmt_addr_match_o);
  COV_CHIRP_ABORT: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    st_reg.hs == HSC_HS_CHIRP_J ##1 st_reg.hs == HSC_HS_IDLE);
endmodule // hsc_strap_flags

// file: tb/hsc_usb_far_end.sv
// Far end model: line events the analog front end reports.
// Assumes the bench calls its tasks; lines move at falling edges.
`timescale 1ns/100ps
module hsc_usb_far_end (
  // Clock
  input wire logic clk_sys_i,
  // Line events
  output logic fixture_detect_o,
  output logic test_packet_o,
  output logic bus_reset_o,
  output logic chirp_j_o,
  output logic chirp_k_o,
  output logic squelch_o,
  output logic pullup_detect_o,
  output logic disconnect_o
);
  // Codes: 0 fixture, 1 packet, 2 reset, 3 J, 4 K, 5 squelch,
  // 6 pull-up, 7 disconnect
  initial begin
    fixture_detect_o = 1'b0;
    test_packet_o = 1'b0;
    bus_reset_o = 1'b0;
    chirp_j_o = 1'b0;
    chirp_k_o = 1'b0;
    squelch_o = 1'b0;
    pullup_detect_o = 1'b0;
    disconnect_o = 1'b0;
  end
  task automatic set_line(input int b, input logic v);
    case (b)
      0: fixture_detect_o = v;
      1: test_packet_o = v;
      2: bus_reset_o = v;
      3: chirp_j_o = v;
      4: chirp_k_o = v;
      5: squelch_o = v;
      6: pullup_detect_o = v;
      default: disconnect_o = v;
    endcase
  endtask
  // One cycle event, then room for the flag to settle
  task automatic pulse(input int b);
    set_line(b, 1'b1);
    @(negedge clk_sys_i);
    set_line(b, 1'b0);
    repeat (2) @(negedge clk_sys_i);
  endtask
  // reset, one J then K, squelch
  task automatic handshake(input int n);
    pulse(2);
    chirp_j_o = 1'b1;
    repeat (n) @(negedge clk_sys_i);
    // J drops in the cycle K rises, no gap
    chirp_j_o = 1'b0;
    chirp_k_o = 1'b1;
    repeat (n) @(negedge clk_sys_i);
    chirp_k_o = 1'b0;
    @(negedge clk_sys_i);
    pulse(5);
  endtask
endmodule // hsc_usb_far_end

// file: tb/hsc_strap_flags_tb_top.sv
// Bench for strap sampling and status flags, short chirp limits.
// Assumes the far end model drives every line event input.
`timescale 1ns/100ps
module hsc_strap_flags_tb_top;
  import hsc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic power_up_i = 1'b0;
  logic mdata = 1'b0;
  logic mclk = 1'b0;
  logic shigh = 1'b0;
  logic sfloat = 1'b0;
  logic bfloat = 1'b0;
  logic [1:0] blev = 2'h0;
  logic [6:0] addr = 7'h00;
  logic fix, tpk, brst, cj, ck, sq, pu, dis;
  logic match, mode, shut, hs, hs_oe_n, cd, cd_oe_n, cd_wire;
  logic [1:0] sens, boost;
  logic [6:0] tab [3] = '{7'h14, 7'h09, 7'h02};
  logic [3:0] exp_tab [3] = '{4'hb, 4'h5, 4'h2};
  // Chirp lengths: inside, both window ends, then just outside and far out
  int lens [7] = '{8, 5, 20, 4, 21, 3, 25};
  int n_errors = 0;
  int samples_checked = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  // Pin level seen back: our output while driven, else strap
  assign cd_wire = cd_oe_n ? mclk : cd;

  hsc_usb_far_end i_hsc_usb_far_end (.clk_sys_i(clk_sys_i),
    .fixture_detect_o(fix), .test_packet_o(tpk), .bus_reset_o(brst),
    .chirp_j_o(cj), .chirp_k_o(ck), .squelch_o(sq),
    .pullup_detect_o(pu), .disconnect_o(dis));
  hsc_strap_flags #(.MIN_CYC(5), .MAX_CYC(20)) i_hsc_strap_flags (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .power_up_i(power_up_i),
    .mgmt_data_pin_i(mdata), .mgmt_clock_attach_flag_pin_i(cd_wire),
    .sens_strap_high_i(shigh), .sens_strap_float_i(sfloat),
    .boost_float_i(bfloat), .boost_level_i(blev),
    .fixture_detect_i(fix), .test_packet_i(tpk), .bus_reset_i(brst),
    .chirp_j_i(cj), .chirp_k_i(ck), .squelch_i(sq),
    .pullup_detect_i(pu), .disconnect_i(dis),
    .mgmt_addr_i(addr), .mgmt_addr_match_o(match), .mgmt_mode_o(mode),
    .rx_sensitivity_strap_o(sens), .boost_level_o(boost),
    .shutdown_o(shut), .sensitivity_strap_hs_flag_pin_o(hs),
    .sensitivity_strap_hs_flag_pin_oe_n_o(hs_oe_n),
    .mgmt_clock_attach_flag_pin_o(cd),
    .mgmt_clock_attach_flag_pin_oe_n_o(cd_oe_n));

  task automatic chk(input string nm, input logic [6:0] e,
                     input logic [6:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Straps are {data, clock, high, float, boost float, boost level}
  task automatic rst(input logic [6:0] s);
    mdata = s[6];
    mclk = s[5];
    shigh = s[4];
    sfloat = s[3];
    bfloat = s[2];
    blev = s[1:0];
    nrst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk("in reset", 7'h13, {shut, hs, cd, hs_oe_n, cd_oe_n});
    nrst_i = 1'b1;
    power_up_i = 1'b1;
    @(negedge clk_sys_i);
    power_up_i = 1'b0;
    @(negedge clk_sys_i);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    for (int i = 0; i < 3; i++) begin
      rst(tab[i]);
      chk("straps", {3'h0, exp_tab[i]}, {mode, hs_oe_n, cd_oe_n, sens, boost});
      chk("running", 7'h0, shut);
    end
    bfloat = 1'b1;
    blev = 2'h3;
    i_hsc_usb_far_end.pulse(0);
    power_up_i = 1'b1;
    @(negedge clk_sys_i);
    power_up_i = 1'b0;
    @(negedge clk_sys_i);
    chk("boost held", 7'h2, boost);
    $display("test straps done");
    rst(7'h70);
    chk("mgmt mode", 7'h7, {mode, hs_oe_n, cd_oe_n});
    addr = 7'h2c;
    #1 chk("addr hit", 7'h1, match);
    @(negedge clk_sys_i);
    addr = 7'h2d;
    #1 chk("addr miss", 7'h0, match);
    i_hsc_usb_far_end.pulse(6);
    chk("no attach", 7'h0, cd);
    $display("test management done");
    rst(7'h02);
    i_hsc_usb_far_end.pulse(0);
    i_hsc_usb_far_end.pulse(1);
    chk("fixture hs", 7'h1, hs);
    i_hsc_usb_far_end.pulse(7);
    chk("hs cleared", 7'h0, hs);
    i_hsc_usb_far_end.pulse(6);
    chk("attach", 7'h1, cd);
    i_hsc_usb_far_end.pulse(7);
    chk("detach", 7'h0, cd);
    // Handshakes after a passing one start from the active state, so bus reset clears
    for (int i = 0; i < 7; i++) begin
      i_hsc_usb_far_end.handshake(lens[i]);
      chk("handshake hs", {6'h0, i < 3}, hs);
    end
    $display("test flags done");
    i_hsc_usb_far_end.pulse(6);
    rst(7'h02);
    chk("restart", 7'h0, {hs, cd});
    $display("test mid reset done");
    complete_run();
  end
endmodule // hsc_strap_flags_tb_top
